// ---- rtl/ietu_top.sv ----
`timescale 1ns/10ps
`include "ietu_cfg.svh"
module ietu_top
    import ietu_pkg::*;
#(
    parameter int NSRC = 6,
    parameter int NCH = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // peripheral requests, one-cycle pulses on clk_i
    input wire logic [NSRC-1:0] req_i,
    // per source enable and priority
    input wire logic [NSRC-1:0] enable_i,
    input wire logic [4*NSRC-1:0] prio_i,
    // per source: route to transfer channel
    input wire logic [NSRC-1:0] xfer_sel_i,
    input wire logic [3*NSRC-1:0] xfer_ch_i,
    // per source clear of the request flag
    input wire logic [NSRC-1:0] clr_i,
    // fast external input: pin, can receive, serial clock
    input wire logic fast_pin_i,
    input wire logic can_receive_line_i,
    input wire logic serial_clk_i,
    input wire logic [1:0] fast_src_i,
    input wire logic [1:0] fast_edge_i,
    // software trap
    input wire logic trap_i,
    input wire logic [7:0] trap_num_i,
    // cpu state
    input wire logic [3:0] cur_prio_i,
    input wire logic ack_i,
    // transfer channel programming
    input wire logic ch_load_i,
    input wire logic [2:0] ch_idx_i,
    input wire logic [15:0] ch_count_i,
    input wire logic ch_cont_i,
    input wire logic ch_inc_dst_i,
    input wire logic ch_word_i,
    input wire logic [23:0] ch_src_i,
    input wire logic [23:0] ch_dst_i,
    // outputs
    output logic [NSRC-1:0] flag_o,
    output logic fast_flag_o,
    output logic irq_o,
    output logic [23:0] vector_o,
    output logic [3:0] irq_prio_o,
    output logic xfer_o,
    output logic [23:0] xfer_src_o,
    output logic [23:0] xfer_dst_o,
    output logic xfer_word_o,
    output logic [2:0] xfer_ch_o
);
    // ps times kHz overflows 32 bits, so the window is worked in 64
    localparam longint LAT_DIV = 1_000_000_000;
    localparam int LAT_MIN = int'((longint'(`IETU_LAT_MIN_PS) *
                                   `IETU_CLK_KHZ + LAT_DIV - 1) / LAT_DIV);
    localparam int LAT_MAX = int'((longint'(`IETU_LAT_MAX_PS) *
                                   `IETU_CLK_KHZ) / LAT_DIV);

    // request flags and arbiter state
    logic [NSRC-1:0] flag_reg;
    ietu_state_t state_reg;
    // fast input synchronisers
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic fast_prev_reg;
    logic fast_flag_reg;
    // channel state
    logic [15:0] cnt_reg [NCH];
    logic [23:0] src_reg [NCH];
    logic [23:0] dst_reg [NCH];
    logic [NCH-1:0] cont_reg;
    logic [NCH-1:0] incd_reg;
    logic [NCH-1:0] word_reg;
    logic [2:0] win_reg;
    // outputs
    logic irq_reg;
    logic [23:0] vec_reg;
    logic [3:0] iprio_reg;
    logic xfer_reg;
    logic [23:0] xsrc_reg;
    logic [23:0] xdst_reg;
    logic xword_reg;
    logic [2:0] xch_reg;

    // fast input selection after sync
    wire logic fast_lvl = (fast_src_i == `IETU_FAST_CAN) ? sync2_reg[1] :
                          (fast_src_i == `IETU_FAST_SCL) ? sync2_reg[2] :
                          sync2_reg[0];
    // edge qualifier
    wire logic rise = fast_lvl & ~fast_prev_reg;
    wire logic fall = ~fast_lvl & fast_prev_reg;
    wire logic fast_evt = (fast_edge_i[0] & rise) | (fast_edge_i[1] & fall);

    // highest enabled pending priority, lowest index on ties
    logic [3:0] best_prio;
    logic [2:0] best_idx;
    logic best_hit;
    always_comb begin
        best_prio = `IETU_PRIO_IDLE;
        best_idx = 3'd0;
        best_hit = 1'b0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (flag_reg[i] && enable_i[i] &&
                prio_i[4*i +: 4] != `IETU_PRIO_IDLE &&
                prio_i[4*i +: 4] >= best_prio) begin
                best_prio = prio_i[4*i +: 4];
                best_idx = 3'(i);
                best_hit = 1'b1;
            end
        end
    end
    // preempt only above current level
    wire logic grant = best_hit && (best_prio > cur_prio_i) &&
                       state_reg == IETU_IDLE && !irq_reg;
    // a trap in the same cycle takes the slot; the flag must survive
    wire logic hw_take = grant && !trap_i;
    wire logic to_xfer = xfer_sel_i[best_idx];
    wire logic [2:0] gch = xfer_ch_i[3*best_idx +: 3];
    // per source vector
    wire logic [23:0] src_vec = `IETU_VEC_BASE +
                                24'(best_idx) * `IETU_VEC_STEP;
    // trap vector: trap number times four
    wire logic [23:0] trap_vec = {14'h0000, trap_num_i, 2'b00};
    wire logic cnt_last = cnt_reg[gch] == `IETU_CNT_LAST ||
                          cnt_reg[gch] == `IETU_CNT_ZERO;
    // pointer advance follows the channel's data size
    wire logic [23:0] ptr_step = word_reg[gch] ? `IETU_STEP_WORD :
                                                 `IETU_STEP_BYTE;
    // latency: grant reaches output in one cycle, below the 4 to 9 cycle window; lat_ok only needs both bounds >= 1
    wire logic lat_ok = LAT_MIN >= 1 && LAT_MAX >= 1;

    // input synchronisers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_reg <= 3'b000;
            sync2_reg <= 3'b000;
            fast_prev_reg <= 1'b0;
        end else begin
            sync1_reg <= {serial_clk_i, can_receive_line_i, fast_pin_i};
            sync2_reg <= sync1_reg;
            fast_prev_reg <= fast_lvl;
        end
    end

    // request flags: set wins over clear
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_reg <= '0;
            fast_flag_reg <= 1'b0;
        end else begin
            for (int i = 0; i < NSRC; i++) begin
                if (req_i[i])
                    flag_reg[i] <= 1'b1;
                else if (clr_i[i] || (hw_take && best_idx == 3'(i)))
                    flag_reg[i] <= 1'b0;
            end
            fast_flag_reg <= fast_evt | (fast_flag_reg & ~ack_i);
        end
    end

    // arbiter and transfer engine
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= IETU_IDLE;
            irq_reg <= 1'b0;
            vec_reg <= 24'h00_0000;
            iprio_reg <= 4'h0;
            xfer_reg <= 1'b0;
            xsrc_reg <= 24'h00_0000;
            xdst_reg <= 24'h00_0000;
            xword_reg <= 1'b0;
            xch_reg <= 3'd0;
            win_reg <= 3'd0;
            cont_reg <= '0;
            incd_reg <= '0;
            word_reg <= '0;
            for (int c = 0; c < NCH; c++) begin
                cnt_reg[c] <= 16'h0000;
                src_reg[c] <= 24'h00_0000;
                dst_reg[c] <= 24'h00_0000;
            end
        end else begin
            xfer_reg <= 1'b0;
            if (ch_load_i) begin
                cnt_reg[ch_idx_i] <= ch_count_i;
                src_reg[ch_idx_i] <= ch_src_i;
                dst_reg[ch_idx_i] <= ch_dst_i;
                cont_reg[ch_idx_i] <= ch_cont_i;
                incd_reg[ch_idx_i] <= ch_inc_dst_i;
                word_reg[ch_idx_i] <= ch_word_i;
            end
            if (irq_reg && ack_i)
                irq_reg <= 1'b0;
            case (state_reg)
                IETU_IDLE: begin
                    if (trap_i && !irq_reg) begin
                        irq_reg <= 1'b1;
                        vec_reg <= trap_vec;
                        iprio_reg <= 4'hF;
                    end else if (grant && lat_ok && to_xfer) begin
                        // single stolen cycle, no vector
                        xfer_reg <= 1'b1;
                        xsrc_reg <= src_reg[gch];
                        xdst_reg <= dst_reg[gch];
                        xword_reg <= word_reg[gch];
                        xch_reg <= gch;
                        if (incd_reg[gch])
                            dst_reg[gch] <= dst_reg[gch] + ptr_step;
                        else
                            src_reg[gch] <= src_reg[gch] + ptr_step;
                        if (!cont_reg[gch])
                            cnt_reg[gch] <= cnt_reg[gch] - 16'd1;
                        win_reg <= best_idx;
                        iprio_reg <= best_prio;
                        if (!cont_reg[gch] && cnt_last)
                            state_reg <= IETU_VECT;
                    end else if (grant) begin
                        irq_reg <= 1'b1;
                        vec_reg <= src_vec;
                        iprio_reg <= best_prio;
                    end
                end
                IETU_VECT: begin
                    // count ran out: vector to the owning source
                    irq_reg <= 1'b1;
                    vec_reg <= `IETU_VEC_BASE + 24'(win_reg) * `IETU_VEC_STEP;
                    state_reg <= IETU_IDLE;
                end
                default: state_reg <= IETU_IDLE;
            endcase
        end
    end

    assign flag_o = flag_reg;
    assign fast_flag_o = fast_flag_reg;
    assign irq_o = irq_reg;
    assign vector_o = vec_reg;
    assign irq_prio_o = iprio_reg;
    assign xfer_o = xfer_reg;
    assign xfer_src_o = xsrc_reg;
    assign xfer_dst_o = xdst_reg;
    assign xfer_word_o = xword_reg;
    assign xfer_ch_o = xch_reg;
endmodule

// ---- rtl/ietu_cfg.svh ----
`ifndef IETU_CFG_SVH
`define IETU_CFG_SVH
// vector base and spacing for capture/compare sources
`define IETU_VEC_BASE 24'h00_0040
`define IETU_VEC_STEP 24'h00_0004
`define IETU_TRAP_BASE 8'h10
// priority level zero never wins arbitration
`define IETU_PRIO_IDLE 4'h0
// response latency window in ps, and cpu clock in kHz
`define IETU_LAT_MIN_PS 78000
`define IETU_LAT_MAX_PS 187500
`define IETU_CLK_KHZ 50000
// edge select encodings
`define IETU_EDGE_RISE 2'b01
`define IETU_EDGE_FALL 2'b10
`define IETU_EDGE_BOTH 2'b11
// fast input source codes; any other code picks the plain pin
`define IETU_FAST_CAN 2'h1
`define IETU_FAST_SCL 2'h2
// pointer step per transfer, byte or word
`define IETU_STEP_BYTE 24'h00_0001
`define IETU_STEP_WORD 24'h00_0002
// counter values that end a counted block at this service
`define IETU_CNT_LAST 16'h0001
`define IETU_CNT_ZERO 16'h0000
`endif

// ---- rtl/ietu_pkg.sv ----
package ietu_pkg;
    // arbiter state
    typedef enum logic [1:0] {
        IETU_IDLE,
        IETU_XFER,
        IETU_VECT
    } ietu_state_t;
endpackage

// ---- tb/ietu_props.sv ----
`timescale 1ns/10ps
// watches the top ports, one clock domain
module ietu_props #(
    parameter int NSRC = 6
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [NSRC-1:0] req_i,
    input wire logic fast_pin_i,
    input wire logic [1:0] fast_src_i,
    input wire logic [1:0] fast_edge_i,
    input wire logic ack_i,
    input wire logic [NSRC-1:0] flag_o,
    input wire logic fast_flag_o,
    input wire logic irq_o,
    input wire logic [23:0] vector_o,
    input wire logic [3:0] irq_prio_o,
    input wire logic xfer_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // routed pin rises while rise detection is on
    sequence s_pin_rise;
        fast_src_i == 2'h0 && fast_edge_i[0] && $rose(fast_pin_i);
    endsequence
    a_flag_set: assert property (req_i[0] |=> flag_o[0])
        else $error("request flag not set");
    a_irq_hold: assert property (irq_o && !ack_i |=> irq_o)
        else $error("call dropped without answer");
    a_ack_clear: assert property (ack_i |=> !irq_o)
        else $error("call stayed after answer");
    a_xfer_quiet: assert property (xfer_o |-> !irq_o)
        else $error("transfer with a branch");
    a_busy_hold: assert property (irq_o && !ack_i |=> !xfer_o)
        else $error("transfer granted while busy");
    a_vec_align: assert property ($rose(irq_o) |-> vector_o[1:0] == 2'h0)
        else $error("vector not on a slot");
    a_prio_live: assert property ($rose(irq_o) |-> irq_prio_o != 4'h0)
        else $error("level zero was serviced");
    a_fast_rise: assert property (s_pin_rise |-> ##[1:8] fast_flag_o)
        else $error("fast edge missed");
endmodule
bind ietu_top ietu_props #(.NSRC(NSRC)) ietu_props_inst (
    .clk_i, .rst_n_i, .req_i, .fast_pin_i, .fast_src_i, .fast_edge_i,
    .ack_i, .flag_o, .fast_flag_o, .irq_o, .vector_o, .irq_prio_o, .xfer_o
);

// ---- tb/ietu_cpu_model.sv ----
`timescale 1ns/10ps
// cpu side: answers a pending call after dly_i cycles
module ietu_cpu_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // pending call, wait, answer pulse
    input wire logic call_i,
    input wire logic [3:0] dly_i,
    output logic ack_o
);
    logic [3:0] wait_reg; // cycles the call has waited
    // falling edge, so the answer is held over one rising edge
    always @(negedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_o <= 1'b0;
            wait_reg <= 4'h0;
        end else if (call_i && !ack_o && wait_reg < dly_i) begin
            wait_reg <= wait_reg + 4'h1;
        end else begin
            // never two pulses: a fresh call would be lost
            ack_o <= call_i && !ack_o;
            wait_reg <= 4'h0;
        end
    end
endmodule

// ---- tb/ietu_bench.sv ----
`timescale 1ns/10ps
module ietu_bench import ietu_pkg::*;;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [5:0] req_i, enable_i, xfer_sel_i, clr_i, flag_o;
    logic [23:0] prio_i, ch_src_i, ch_dst_i, vector_o, xfer_src_o, xfer_dst_o;
    logic [17:0] xfer_ch_i;
    logic fast_pin_i, can_receive_line_i, serial_clk_i, trap_i, ack_i;
    logic ch_load_i, ch_cont_i, ch_inc_dst_i, ch_word_i, hit;
    logic fast_flag_o, irq_o, xfer_o, xfer_word_o;
    logic [1:0] fast_src_i, fast_edge_i;
    logic [7:0] trap_num_i;
    logic [3:0] cur_prio_i, irq_prio_o, dly;
    logic [2:0] ch_idx_i, xfer_ch_o;
    logic [15:0] ch_count_i;
    int n_errors = 0;
    int checked = 0;
    // 0 call, 1 transfer, 2 fast flag, 3 call gone, 4 fast gone
    wire [4:0] outs = {!fast_flag_o, !irq_o, fast_flag_o, xfer_o, irq_o};
    always #10 clk_i = ~clk_i;
    ietu_top ietu_top_inst (.*);
    ietu_cpu_model ietu_cpu_model_inst (.clk_i, .rst_n_i,
        .call_i(irq_o | fast_flag_o), .dly_i(dly), .ack_o(ack_i));
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            n_errors++;
        end
    endtask
    // bounded poll, returns at once when seen
    task automatic seen(input int sel);
        int n;
        n = 0;
        hit = 1'b0;
        while (!hit && n < 12) begin
            @(negedge clk_i);
            n++;
            hit = outs[sel] === 1'b1;
        end
    endtask
    task automatic pulse(input logic [5:0] m);
        req_i = m;
        @(negedge clk_i);
        req_i = 6'h00;
    endtask
    // each source calls its own slot at its own level
    task automatic t_vec;
        for (int s = 0; s < 6; s++) begin
            pulse(6'h01 << s);
            seen(0);
            chk(24'(hit), 24'h1);
            chk(vector_o, 24'h00_0040 + 24'(4 * s));
            chk(24'(irq_prio_o), 24'(s + 2));
            seen(3);
        end
    endtask
    // two at once, then one held back by the cpu level
    task automatic t_prio;
        pulse(6'h12);
        seen(0);
        chk(vector_o, 24'h00_0050);
        seen(3);
        seen(0);
        chk(vector_o, 24'h00_0044);
        seen(3);
        cur_prio_i = 4'h2;
        pulse(6'h01);
        seen(0);
        chk(24'(hit), 24'h0);
        cur_prio_i = 4'h0;
        seen(0);
        chk(vector_o, 24'h00_0040);
        seen(3);
    endtask
    // channel 7 moves words for source 2; count 2 ends in a call
    task automatic t_xfer;
        {ch_idx_i, ch_count_i, ch_dst_i} = {3'h7, 16'h0002, 24'h00_2000};
        {ch_inc_dst_i, ch_word_i, ch_load_i} = 3'h7;
        @(negedge clk_i);
        ch_load_i = 1'b0;
        xfer_sel_i = 6'h04;
        xfer_ch_i = 18'h0_01c0;
        for (int i = 0; i < 2; i++) begin
            pulse(6'h04);
            seen(1);
            chk(xfer_dst_o, 24'h00_2000 + 24'(2 * i));
            chk(24'({xfer_ch_o, xfer_word_o}), 24'h00_000f);
            @(negedge clk_i);
            chk(24'(irq_o), 24'(i));
            if (i == 1) chk(vector_o, 24'h00_0048);
        end
        seen(3);
    endtask
    // channel 3, continuous bytes for source 5: source moves, no call
    task automatic t_cont;
        {ch_idx_i, ch_count_i, ch_src_i} = {3'h3, 16'h0001, 24'h00_1000};
        {ch_cont_i, ch_inc_dst_i, ch_word_i, ch_load_i} = 4'h9;
        @(negedge clk_i);
        {ch_load_i, ch_cont_i} = 2'h0;
        xfer_sel_i = 6'h20;
        xfer_ch_i = 18'h1_8000;
        for (int i = 0; i < 2; i++) begin
            pulse(6'h20);
            seen(1);
            chk(24'(hit), 24'h1);
            chk(xfer_src_o, 24'h00_1000 + 24'(i));
            chk(xfer_dst_o, 24'h00_2000);
            chk(24'({xfer_ch_o, xfer_word_o}), 24'h00_0006);
            @(negedge clk_i);
            chk(24'(irq_o), 24'h0);
        end
        xfer_sel_i = 6'h00;
    endtask
    // flag held by cpu level; reset, set-beats-clear, then clear
    task automatic t_flag;
        cur_prio_i = 4'hf;
        pulse(6'h08);
        chk(24'(flag_o), 24'h00_0008);
        rst_n_i = 1'b0;
        @(negedge clk_i);
        chk(24'({flag_o, irq_o, xfer_o, fast_flag_o}), 24'h0);
        chk(vector_o, 24'h00_0000);
        rst_n_i = 1'b1;
        {req_i, clr_i} = {6'h08, 6'h08};
        @(negedge clk_i);
        req_i = 6'h00;
        chk(24'(flag_o), 24'h00_0008);
        @(negedge clk_i);
        clr_i = 6'h00;
        chk(24'(flag_o), 24'h0);
        cur_prio_i = 4'h0;
    endtask
    // trap number picks the slot; then every fast input and edge
    task automatic t_trap_fast;
        trap_num_i = 8'h15;
        trap_i = 1'b1;
        @(negedge clk_i);
        trap_i = 1'b0;
        chk(24'(irq_o), 24'h1);
        chk(vector_o, 24'h00_0054);
        chk(24'(irq_prio_o), 24'h00_000f);
        seen(3);
        for (int s = 0; s < 3; s++) begin
            for (int e = 1; e < 4; e++) begin
                {fast_src_i, fast_edge_i} = {2'(s), 2'(e)};
                {serial_clk_i, can_receive_line_i, fast_pin_i} = 3'(1 << s);
                seen(2);
                chk(24'(hit), 24'(e & 1));
                seen(4);
                {serial_clk_i, can_receive_line_i, fast_pin_i} = 3'h0;
                seen(2);
                chk(24'(hit), 24'(e >> 1));
                seen(4);
            end
        end
    endtask
    task automatic summarize;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        {req_i, clr_i, xfer_sel_i, xfer_ch_i, trap_i, trap_num_i} = '0;
        {fast_pin_i, can_receive_line_i, serial_clk_i, fast_src_i} = '0;
        {ch_load_i, ch_idx_i, ch_count_i, ch_cont_i, ch_inc_dst_i} = '0;
        {ch_word_i, ch_src_i, ch_dst_i, cur_prio_i, fast_edge_i} = '0;
        {enable_i, prio_i, dly} = {6'h3f, 24'h76_5432, 4'h2};
        repeat (12) @(negedge clk_i);
        rst_n_i = 1'b1;
        @(negedge clk_i);
        t_vec();
        t_prio();
        t_xfer();
        t_cont();
        t_flag();
        dly = 4'h0;
        t_trap_fast();
        summarize();
    end
    // the run needs under 2000 cycles; far past that is a hang
    initial begin
        #200000;
        n_errors++;
        summarize();
    end
endmodule
